// file: cio_core_irq.sv
`timescale 1ns/100ps
module cio_core_irq (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [cio_pkg::ADDR_W-1:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [7:0] regRdata,
    input wire logic timer0Overflow,
    input wire logic externalPin,
    input wire logic portChangePin,
    input wire logic peripheralRequest,
    output logic coreIrq,
    output logic [7:0] timerOptionControl,
    output logic [cio_pkg::DIV_W-1:0] timer0Divide,
    output logic [cio_pkg::DIV_W-1:0] watchdogDivide
);
    logic [7:0] interruptControl;
    logic [7:0] next_interruptControl;
    logic [1:0] extSync;
    logic [1:0] pcSync;
    logic extLast;
    logic pcLast;
    logic extEvent;
    logic pcEvent;
    logic selIrq;
    logic selOpt;
    logic pinIrq;
    logic pcFlagKnown;
    logic [7:1] irqCtrlUpper;
    logic irqCtrlFlag0;
    cio_presc_if presc();

    // ------------------------------------------------
    // Address decode
    // ------------------------------------------------
    assign selIrq = regAddr[cio_pkg::BANK_LSB-1:0] == cio_pkg::IRQ_CTRL_LOW;
    assign selOpt = regAddr[cio_pkg::BANK_LSB-1:0] == cio_pkg::OPT_CTRL_LOW
        && regAddr[cio_pkg::BANK_LSB];

    // ------------------------------------------------
    // Pin synchronisers and edge detect
    // ------------------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            extSync <= 2'h0;
            pcSync <= 2'h0;
            extLast <= 1'b0;
            pcLast <= 1'b0;
        end else begin
            extSync <= {extSync[0], externalPin};
            pcSync <= {pcSync[0], portChangePin};
            extLast <= extSync[1];
            pcLast <= pcSync[1];
        end
    end

    // Edge select: one rising, zero falling
    assign extEvent = timerOptionControl[cio_pkg::EDGE_SEL_BIT]
        ? (extSync[1] && !extLast) : (!extSync[1] && extLast);
    assign pcEvent = pcSync[1] != pcLast;

    // ------------------------------------------------
    // Interrupt control register
    // ------------------------------------------------
    always_comb begin
        next_interruptControl = interruptControl;
        if (regWrite && selIrq) begin
            next_interruptControl = regWdata;
        end
        // Event beats a clearing write in the same cycle
        if (timer0Overflow) begin
            next_interruptControl[cio_pkg::T0F_BIT] = 1'b1;
        end
        if (extEvent) begin
            next_interruptControl[cio_pkg::PINF_BIT] = 1'b1;
        end
        if (pcEvent) begin
            next_interruptControl[cio_pkg::PCF_BIT] = 1'b1;
        end
    end

    // Bit 0 keeps no reset: it powers up undefined
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            irqCtrlUpper <= cio_pkg::IRQ_CTRL_RESET[7:1];
        end else begin
            irqCtrlUpper <= next_interruptControl[7:1];
        end
    end

    always_ff @(posedge clock) begin
        irqCtrlFlag0 <= next_interruptControl[0];
    end

    assign interruptControl = {irqCtrlUpper, irqCtrlFlag0};

    // Tracks whether bit 0 has ever been defined; gates the port change request
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pcFlagKnown <= 1'b0;
        end else if (pcEvent || (regWrite && selIrq)) begin
            pcFlagKnown <= 1'b1;
        end
    end

    // ------------------------------------------------
    // Option control register
    // ------------------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            timerOptionControl <= cio_pkg::OPT_CTRL_RESET;
        end else if (regWrite && selOpt) begin
            timerOptionControl <= regWdata;
        end
    end

    // ------------------------------------------------
    // Read data, one cycle after the strobe
    // ------------------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            regRdata <= 8'h00;
        end else if (regRead && selIrq) begin
            regRdata <= interruptControl;
        end else if (regRead && selOpt) begin
            regRdata <= timerOptionControl;
        end else begin
            regRdata <= 8'h00;
        end
    end

    // ------------------------------------------------
    // Request to the core
    // ------------------------------------------------
    assign pinIrq = (interruptControl[cio_pkg::T0_EN_BIT] && interruptControl[cio_pkg::T0F_BIT])
        || (interruptControl[cio_pkg::PINIE_BIT] && interruptControl[cio_pkg::PINF_BIT])
        || (interruptControl[cio_pkg::PCIE_BIT] && interruptControl[cio_pkg::PCF_BIT] && pcFlagKnown)
        || (interruptControl[cio_pkg::PERIPH_EN_BIT] && peripheralRequest);
    assign coreIrq = interruptControl[cio_pkg::GLOBAL_EN_BIT] && pinIrq;

    // ------------------------------------------------
    // Prescaler
    // ------------------------------------------------
    assign presc.assignWatchdog = timerOptionControl[cio_pkg::ASSIGN_SEL_BIT];
    assign presc.rateSelect = timerOptionControl[cio_pkg::RATE_MSB:0];
    assign timer0Divide = presc.timer0Divide;
    assign watchdogDivide = presc.watchdogDivide;

    cio_presc_decode u_decode (
        .p(presc.dec)
    );

    // ------------------------------------------------
    // Checks
    // ------------------------------------------------
    sequence irqWriteSeq;
        regWrite && selIrq;
    endsequence

    sequence irqReadSeq;
        regRead && selIrq;
    endsequence

    sequence optWriteSeq;
        regWrite && selOpt;
    endsequence

    sequence optReadSeq;
        regRead && selOpt;
    endsequence

    global_gate_a: assert property (@(posedge clock) disable iff (!rst_n)
        !interruptControl[cio_pkg::GLOBAL_EN_BIT] |-> !coreIrq)
        else $error("request passed with global enable low");
    timer_flag_a: assert property (@(posedge clock) disable iff (!rst_n)
        timer0Overflow |=> interruptControl[cio_pkg::T0F_BIT])
        else $error("timer0 flag missed");
    pin_flag_a: assert property (@(posedge clock) disable iff (!rst_n)
        extEvent |=> interruptControl[cio_pkg::PINF_BIT])
        else $error("pin flag missed");
    port_flag_a: assert property (@(posedge clock) disable iff (!rst_n)
        pcEvent |=> interruptControl[cio_pkg::PCF_BIT])
        else $error("port change flag missed");
    timer_irq_a: assert property (@(posedge clock) disable iff (!rst_n)
        (interruptControl[cio_pkg::GLOBAL_EN_BIT] && interruptControl[cio_pkg::T0_EN_BIT]
        && interruptControl[cio_pkg::T0F_BIT]) |-> coreIrq)
        else $error("timer0 request not raised");
    port_irq_a: assert property (@(posedge clock) disable iff (!rst_n)
        (interruptControl[cio_pkg::GLOBAL_EN_BIT] && interruptControl[cio_pkg::PCIE_BIT]
        && interruptControl[cio_pkg::PCF_BIT] && pcFlagKnown) |-> coreIrq)
        else $error("port change request not raised");
    periph_gate_a: assert property (@(posedge clock) disable iff (!rst_n)
        (peripheralRequest && !interruptControl[cio_pkg::PERIPH_EN_BIT]
        && !interruptControl[cio_pkg::T0_EN_BIT] && !interruptControl[cio_pkg::PINIE_BIT]
        && !interruptControl[cio_pkg::PCIE_BIT]) |-> !coreIrq)
        else $error("peripheral passed while disabled");
    periph_pass_a: assert property (@(posedge clock) disable iff (!rst_n)
        (interruptControl[cio_pkg::GLOBAL_EN_BIT] && interruptControl[cio_pkg::PERIPH_EN_BIT]
        && peripheralRequest) |-> coreIrq)
        else $error("peripheral request not raised");
    irq_write_a: assert property (@(posedge clock) disable iff (!rst_n)
        irqWriteSeq |=> interruptControl[cio_pkg::GLOBAL_EN_BIT:cio_pkg::PCIE_BIT]
        == $past(regWdata[cio_pkg::GLOBAL_EN_BIT:cio_pkg::PCIE_BIT]))
        else $error("interrupt control write lost");
    irq_read_a: assert property (@(posedge clock) disable iff (!rst_n)
        irqReadSeq |=> regRdata[cio_pkg::GLOBAL_EN_BIT:cio_pkg::PINF_BIT]
        == $past(interruptControl[cio_pkg::GLOBAL_EN_BIT:cio_pkg::PINF_BIT]))
        else $error("interrupt control read wrong");
    unmapped_read_a: assert property (@(posedge clock) disable iff (!rst_n)
        (regRead && !selIrq && !selOpt) |=> regRdata == 8'h00)
        else $error("unmapped read not zero");
    opt_write_a: assert property (@(posedge clock) disable iff (!rst_n)
        optWriteSeq |=> timerOptionControl == $past(regWdata))
        else $error("option write lost");
    opt_mirror_a: assert property (@(posedge clock) disable iff (!rst_n)
        optWriteSeq ##1 optReadSeq |=> regRdata == $past(regWdata, 2))
        else $error("option readback wrong");
    presc_one_a: assert property (@(posedge clock) disable iff (!rst_n)
        timer0Divide == 9'h001 || watchdogDivide == 9'h001)
        else $error("prescaler given to both");
    watchdog_rate_a: assert property (@(posedge clock) disable iff (!rst_n)
        timerOptionControl[cio_pkg::ASSIGN_SEL_BIT]
        |-> watchdogDivide == (9'h001 << timerOptionControl[cio_pkg::RATE_MSB:0]))
        else $error("watchdog rate wrong");
    timer_rate_a: assert property (@(posedge clock) disable iff (!rst_n)
        !timerOptionControl[cio_pkg::ASSIGN_SEL_BIT] |-> timer0Divide
        == (9'h001 << ({1'b0, timerOptionControl[cio_pkg::RATE_MSB:0]} + 4'h1)))
        else $error("timer0 rate wrong");
endmodule : cio_core_irq

// file: cio_pkg.sv
// How it works
// - One read/write interrupt control register holds enable and flag for timer0, port change and pin.
// - Interrupt control answers at the same location in every bank; reset clears bits 7..1, bit 0 is left as is.
// - Option control is mirrored at two locations, all eight bits read/write, reset to all ones.
// - Each flag sets on its event regardless of its own enable and the global enable.
// - Bit 7 is the global enable; when zero no request reaches the core.
// - Bit 5 enables the timer0 overflow interrupt.
// - The one prescaler serves only timer0 or only the watchdog at a time.
// - No peripheral request reaches the core unless bit 6 is set.
package cio_pkg;
    localparam int ADDR_W = 9;
    // Bank offsets (low seven bits decoded): interrupt control mirrored in every bank, option control only where address bit 7 is set
    localparam logic [6:0] IRQ_CTRL_LOW = 7'h0B;
    localparam logic [6:0] OPT_CTRL_LOW = 7'h01;
    localparam logic [8:0] IRQ_CTRL_ADDR = 9'h00B;
    localparam logic [8:0] OPT_CTRL_ADDR = 9'h081;
    localparam int BANK_LSB = 7;
    localparam logic [7:0] IRQ_CTRL_RESET = 8'h00;
    localparam logic [7:0] OPT_CTRL_RESET = 8'hFF;
    // Interrupt control fields
    localparam int GLOBAL_EN_BIT = 7;
    localparam int PERIPH_EN_BIT = 6;
    localparam int T0_EN_BIT = 5;
    localparam int PINIE_BIT = 4;
    localparam int PCIE_BIT = 3;
    localparam int T0F_BIT = 2;
    localparam int PINF_BIT = 1;
    localparam int PCF_BIT = 0;
    // Option control fields
    localparam int PULLUP_DIS_BIT = 7;
    localparam int EDGE_SEL_BIT = 6;
    localparam int T0_SRC_BIT = 5;
    localparam int T0_EDGE_BIT = 4;
    localparam int ASSIGN_SEL_BIT = 3;
    localparam int RATE_MSB = 2;
    localparam int RATE_W = 3;
    localparam int DIV_W = 9;
endpackage : cio_pkg

// file: cio_presc_decode.sv
`timescale 1ns/100ps
module cio_presc_decode (
    cio_presc_if.dec p
);
    localparam logic [cio_pkg::DIV_W-1:0] ONE = 9'h001;

    // ------------------------------------------------
    // Shared prescaler: one user at a time
    // ------------------------------------------------
    always_comb begin
        if (p.assignWatchdog) begin
            p.timer0Divide = ONE;
            p.watchdogDivide = ONE << p.rateSelect;
        end else begin
            // Shift count widened so rate 7 reaches the top bit
            p.timer0Divide = ONE << ({1'b0, p.rateSelect} + 4'h1);
            p.watchdogDivide = ONE;
        end
    end
endmodule : cio_presc_decode

// file: cio_presc_if.sv
`timescale 1ns/100ps
interface cio_presc_if;
    logic assignWatchdog;
    logic [cio_pkg::RATE_W-1:0] rateSelect;
    logic [cio_pkg::DIV_W-1:0] timer0Divide;
    logic [cio_pkg::DIV_W-1:0] watchdogDivide;
    modport ctrl (output assignWatchdog, output rateSelect, input timer0Divide,
        input watchdogDivide);
    modport dec (input assignWatchdog, input rateSelect, output timer0Divide,
        output watchdogDivide);
endinterface : cio_presc_if

// file: tb_top.sv
`timescale 1ns/100ps
module tb_top;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [cio_pkg::ADDR_W-1:0] regAddr = '0;
    logic [7:0] regWdata = 8'h00;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic [7:0] regRdata;
    logic timer0Overflow = 1'b0;
    logic externalPin = 1'b0;
    logic portChangePin = 1'b0;
    logic peripheralRequest = 1'b0;
    logic coreIrq;
    logic [7:0] timerOptionControl;
    logic [cio_pkg::DIV_W-1:0] timer0Divide;
    logic [cio_pkg::DIV_W-1:0] watchdogDivide;
    logic [7:0] rdVal;
    int num_errors = 0;
    int cmp_count = 0;

    cio_core_irq cio_core_irq_i (.clock(clock), .rst_n(rst_n), .regAddr(regAddr),
        .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
        .timer0Overflow(timer0Overflow), .externalPin(externalPin),
        .portChangePin(portChangePin), .peripheralRequest(peripheralRequest),
        .coreIrq(coreIrq), .timerOptionControl(timerOptionControl),
        .timer0Divide(timer0Divide), .watchdogDivide(watchdogDivide));

    always #5 clock = ~clock;

    // ----------------------------------------
    // Bus cycles and comparison
    // ----------------------------------------
    task automatic chk(input string name, input logic [8:0] exp, input logic [8:0] got);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [8:0] addr, input logic [7:0] data);
        @(posedge clock);
        regWrite <= 1'b1;
        regAddr <= addr;
        regWdata <= data;
        @(posedge clock);
        regWrite <= 1'b0;
        #1;
    endtask : wr

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [8:0] addr);
        @(posedge clock);
        regRead <= 1'b1;
        regAddr <= addr;
        @(posedge clock);
        regRead <= 1'b0;
        #1;
        rdVal = regRdata;
    endtask : rd

    // Write then read with no idle cycle between the strobes
    task automatic wrRd(input logic [8:0] waddr, input logic [8:0] raddr, input logic [7:0] data);
        @(posedge clock);
        regWrite <= 1'b1;
        regAddr <= waddr;
        regWdata <= data;
        @(posedge clock);
        regWrite <= 1'b0;
        regRead <= 1'b1;
        regAddr <= raddr;
        @(posedge clock);
        regRead <= 1'b0;
        #1;
        rdVal = regRdata;
    endtask : wrRd

    task automatic pinWait();
        repeat (4) @(posedge clock);
        #1;
    endtask : pinWait

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : end_sim

    initial begin
        repeat (20000) @(posedge clock);
        num_errors++;
        end_sim();
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (10) @(posedge clock);
        rst_n <= 1'b1;
        rd(cio_pkg::OPT_CTRL_ADDR); chk("opt reset", 9'h0FF, {1'b0, rdVal});
        rd(9'h181); chk("opt mirror reset", 9'h0FF, {1'b0, rdVal});
        rd(9'h18B); chk("irq reset", 9'h000, {1'b0, rdVal & 8'hFE});
        chk("wd div reset", 9'h080, watchdogDivide);
        chk("t0 div reset", 9'h001, timer0Divide);
        wrRd(9'h181, 9'h081, 8'h5A); chk("opt back to back", 9'h05A, {1'b0, rdVal});
        chk("wd div rate", 9'h004, watchdogDivide);
        for (int r = 0; r < 8; r++) begin
            for (int s = 0; s < 2; s++) begin
                wr(s[0] ? 9'h181 : 9'h081, {4'h0, s[0], r[2:0]});
                chk("opt out", {5'h00, s[0], r[2:0]}, {1'b0, timerOptionControl});
                chk("t0 div", s[0] ? 9'h001 : 9'(1 << (r + 1)), timer0Divide);
                chk("wd div", s[0] ? 9'(1 << r) : 9'h001, watchdogDivide);
            end
        end
        chk("t0 one to one", 9'h001, timer0Divide);
        rd(9'h081); chk("opt mirror", 9'h00F, {1'b0, rdVal});
        rd(9'h001); chk("opt bank0", 9'h000, {1'b0, rdVal});
        wr(9'h10B, 8'h78);
        rd(9'h08B); chk("irq mirror", 9'h078, {1'b0, rdVal});
        rd(9'h00B); chk("irq rw", 9'h078, {1'b0, rdVal});
        // Flags first cleared so a stale one cannot fire on enable
        wr(9'h00B, 8'h00);
        @(posedge clock) timer0Overflow <= 1'b1;
        @(posedge clock) timer0Overflow <= 1'b0;
        #1;
        chk("gie off", 9'h000, {8'h00, coreIrq});
        rd(9'h00B); chk("t0 flag", 9'h004, {1'b0, rdVal});
        wr(9'h00B, 8'hA0); chk("t0 en clean", 9'h000, {8'h00, coreIrq});
        @(posedge clock) timer0Overflow <= 1'b1;
        @(posedge clock) timer0Overflow <= 1'b0;
        #1;
        chk("t0 irq", 9'h001, {8'h00, coreIrq});
        wr(9'h00B, 8'h84); chk("t0 masked", 9'h000, {8'h00, coreIrq});
        wr(9'h00B, 8'h24); chk("gie masks", 9'h000, {8'h00, coreIrq});
        // Pin edge select: rising first, then falling
        wr(9'h081, 8'h40);
        wr(9'h00B, 8'h00);
        @(posedge clock) externalPin <= 1'b1;
        pinWait();
        rd(9'h00B); chk("pin rise", 9'h002, {1'b0, rdVal});
        wr(9'h00B, 8'h00);
        wr(9'h081, 8'h00);
        @(posedge clock) externalPin <= 1'b0;
        pinWait();
        rd(9'h00B); chk("pin fall", 9'h002, {1'b0, rdVal});
        wr(9'h00B, 8'h00);
        @(posedge clock) externalPin <= 1'b1;
        pinWait();
        rd(9'h00B); chk("pin wrong edge", 9'h000, {1'b0, rdVal});
        @(posedge clock) portChangePin <= 1'b1;
        pinWait();
        rd(9'h00B); chk("port flag", 9'h001, {1'b0, rdVal});
        wr(9'h00B, 8'h89); chk("port irq", 9'h001, {8'h00, coreIrq});
        wr(9'h00B, 8'h90); chk("pin en no flag", 9'h000, {8'h00, coreIrq});
        @(posedge clock) peripheralRequest <= 1'b1;
        @(posedge clock);
        #1;
        chk("periph blocked", 9'h000, {8'h00, coreIrq});
        wr(9'h00B, 8'hC0); chk("periph irq", 9'h001, {8'h00, coreIrq});
        wr(9'h00B, 8'h40); chk("periph gie", 9'h000, {8'h00, coreIrq});
        rd(9'h005); chk("unmapped", 9'h000, {1'b0, rdVal});
        end_sim();
    end
endmodule : tb_top
